// ==== src/stc_counters.sv ====
// Retry counter, step counter, cycle counter and test-step sequencer of the scan facility.
// Notes on behaviour
// - Retry counter loads 31 at the start of each test read-in.
// - Each read-in error decrements the retry counter and retries the failed test.
// - An error with the counter already at zero, the 32nd, abandons read-in.
// - Retry counter only loads 31 or decrements through the shared decrementer.
// - Load-retry order with gap trigger set loads 31.
// - Sequencer reading 0 or 6, or 1 with repeat latch, loads 31.
// - Sequencer 4 with pass loads 31 unless error, unconditional bit, fail or zero result.
// - Initial load or test restart loads 31.
// - Logic tests decrement on the order; control-store tests decrement on input error.
// - Four high bits plus two test-clock bits form a six-position step counter.
// - Control-word load order copies bits 58-63 into step counter outside control-store tests.
// - In control-store tests sequencer value 2 loads the cycle count field.
// - Test-clock pair counts 3 down to 0, once per scan tick.
// - Pair at zero decrements high bits via decrementer and reloads 3.
// - Step counter decrements only with control latch, no store request, not zero.
// - Control trigger set by order in logic tests, sequencer 2, or address compare in count-log.
// - All six bits zero sets the zero latch (in pulse and count-log modes all eleven bits zero), which blocks further decrements.
// - Pulse and count-log modes chain address sequencer, step counter, pair: 11 bits.
// - Step counter zero decrements address sequencer, sets pair, reloads all ones.
// - All eleven bits zero raises cycle-zero; count-log then starts a logout.
// - Sequencer set to 7 at test start, decremented at test-clock 3.
// - Sequencer values 0-6 decode into one of seven step signals; 7 decodes to none.
// - Cycle counter zero or test step counter zero sets the clock-stop trigger.
//
// The register addresses and strobed register access are this design's own decisions.
`include "stc_map.svh"
module stc_counters (
  input  wire logic                   clk_sys_i,
  input  wire logic                   rst_i,
  input  wire stc_pkg::stc_orders_t   ord_i,
  input  wire stc_pkg::stc_cond_t     cond_i,
  input  wire logic                   scan_tick_i,
  input  wire logic [5:0]             wreg_cc_i,
  input  wire logic [4:0]             addr_seq_i,
  input  wire logic [`STC_ADDR_W-1:0] addr_i,
  input  wire logic [31:0]            wdata_i,
  input  wire logic                   wr_i,
  input  wire logic                   rd_i,
  output logic      [31:0]            rdata_o,
  output logic                        retry_o,
  output logic                        abandon_o,
  output logic                        addr_seq_wr_o,
  output logic      [4:0]             addr_seq_val_o,
  output logic      [6:0]             step_o,
  output logic                        cyc_zero_o,
  output logic                        logout_o,
  output logic                        clk_stop_o
);
  import stc_pkg::*;

  stc_mode_t   mode_q;
  logic        acmp_q;
  logic [4:0]  retry_q;
  logic        retry_pend_q;
  logic [3:0]  hi_q;
  logic [1:0]  tclk_q;
  logic        ctl_q;
  logic        zero_q;
  logic [2:0]  seq_q;
  logic        seq_pend_q;
  logic        enter_q;
  logic        stop_q;
  logic        cyc_zero_q;
  logic [31:0] rdata_q;
  logic        retry_q_o;
  logic        abandon_q;
  logic        aseq_wr_q;
  logic [4:0]  aseq_val_q;
  logic [6:0]  step_q;
  logic        logout_q;

  wire logic cs_w   = (mode_q == STC_CSTEST);
  wire logic lg_w   = (mode_q == STC_LOGIC);
  wire logic cyc_w  = (mode_q == STC_PULSE) || (mode_q == STC_CNTLOG);
  wire logic low0_w = (tclk_q == 2'h0);
  wire logic hi0_w  = (hi_q == 4'h0);
  wire logic all0_w = low0_w && hi0_w;
  wire logic aseq0_w = (addr_seq_i == 5'h00);
  wire logic run_w  = ctl_q && !cond_i.scan_store_request_trigger && !zero_q;
  wire logic steptk_w = run_w && scan_tick_i;

  // Step counter, test-clock pair and cycle counter control.
  wire logic hi_req_w  = steptk_w && low0_w && !hi0_w;
  wire logic cyc_wrap_w = cyc_w && steptk_w && all0_w && !aseq0_w;
  wire logic zero_set_w = ctl_q && !zero_q && all0_w && !(cyc_w && !aseq0_w);
  wire logic cyc_all0_w = cyc_w && ctl_q && all0_w && aseq0_w;
  wire logic ld_cw_w   = ord_i.load_control_word_order && !cs_w;
  wire logic ld_cs_w   = cs_w && enter_q && (seq_q == 3'h2);
  wire logic ld_step_w = ld_cw_w || ld_cs_w;
  wire logic ctl_set_w = (lg_w && ord_i.set_counter_control_order) || ld_cs_w
                      || (mode_q == STC_CNTLOG && acmp_q && cond_i.addr_match);

  // Retry counter control.
  wire logic sq_ok_w = !cond_i.input_error && !cond_i.unconditional_test_bit
                    && !cond_i.fail_trigger && !cond_i.result_zero;
  wire logic ld_seq_w = cs_w && enter_q && ((seq_q == 3'h0) || (seq_q == 3'h6)
                      || (seq_q == 3'h1 && cond_i.repeat_latch)
                      || (seq_q == 3'h4 && cond_i.pass_trigger && sq_ok_w));
  wire logic ld_retry_w = (ord_i.load_retry_order && cond_i.gap_trigger) || ld_seq_w
                       || ord_i.initial_load || ord_i.test_restart;
  wire logic err_w = (lg_w && ord_i.decrement_retry_order) || (cs_w && cond_i.input_error);
  wire logic err_ok_w = err_w && !ld_retry_w && (retry_q != 5'h00) && !retry_pend_q;
  wire logic err_end_w = err_w && !ld_retry_w && (retry_q == 5'h00) && !retry_pend_q;

  // Test-step sequencer control.
  wire logic seq_req_w = cs_w && scan_tick_i && (tclk_q == `STC_TCLK_MAX) && (seq_q != 3'h0);

  // Shared decrementer requests, one grant per cycle.
  wire logic [`STC_CH_N-1:0]      req_w;
  wire logic [`STC_CH_N-1:0][4:0] val_w;
  logic      [`STC_CH_N-1:0]      gnt_w;
  logic      [4:0]                dec_w;
  logic      [6:0]                step_w;

  assign req_w[`STC_CH_STEP]  = hi_req_w;
  assign req_w[`STC_CH_ADDR]  = cyc_wrap_w;
  assign req_w[`STC_CH_SEQ]   = seq_pend_q || seq_req_w;
  assign req_w[`STC_CH_RETRY] = retry_pend_q && !ld_retry_w;
  assign val_w[`STC_CH_STEP]  = {1'b0, hi_q};
  assign val_w[`STC_CH_ADDR]  = addr_seq_i;
  assign val_w[`STC_CH_SEQ]   = {2'b00, seq_q};
  assign val_w[`STC_CH_RETRY] = retry_q;

  stc_scan_decr u_decr (
    .req_i (req_w),
    .val_i (val_w),
    .gnt_o (gnt_w),
    .res_o (dec_w)
  );

  stc_step_decoder u_dec (
    .seq_i  (seq_q),
    .step_o (step_w)
  );

  wire logic wr_ctrl_w = wr_i && (addr_i == `STC_REG_CTRL);
  wire logic clr_stop_w = wr_ctrl_w && wdata_i[`STC_CTRL_CLR_BIT];
  wire logic [31:0] stat_w = {26'h0, cyc_zero_q, stop_q, zero_q, ctl_q, seq_pend_q, retry_pend_q};
  wire logic [31:0] cnt_w  = {18'h0, seq_q, hi_q, tclk_q, retry_q};
  wire logic [31:0] ctrl_w = {29'h0, acmp_q, mode_q};
  wire logic [31:0] rmux_w = (addr_i == `STC_REG_CTRL) ? ctrl_w
                           : (addr_i == `STC_REG_STAT) ? stat_w
                           : (addr_i == `STC_REG_CNT)  ? cnt_w : 32'h0;

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      {acmp_q, mode_q} <= `STC_CTRL_RST;
      rdata_q <= 32'h0;
    end
    else
    begin
      if (wr_ctrl_w)
      begin
        mode_q <= stc_mode_t'(wdata_i[`STC_CTRL_MODE_LSB +: 2]);
        acmp_q <= wdata_i[`STC_CTRL_ACMP_BIT];
      end
      rdata_q <= rd_i ? rmux_w : 32'h0;
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      retry_q      <= `STC_RETRY_MAX;
      retry_pend_q <= 1'b0;
      retry_q_o    <= 1'b0;
      abandon_q    <= 1'b0;
    end
    else
    begin
      if (ld_retry_w)
        retry_q <= `STC_RETRY_MAX;
      else if (gnt_w[`STC_CH_RETRY])
        retry_q <= dec_w;
      retry_pend_q <= !ld_retry_w && (err_ok_w || (retry_pend_q && !gnt_w[`STC_CH_RETRY]));
      retry_q_o    <= err_ok_w;
      abandon_q    <= err_end_w;
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      hi_q   <= 4'h0;
      tclk_q <= 2'h0;
    end
    else if (ld_step_w)
    begin
      hi_q   <= wreg_cc_i[`STC_CC_HI_LSB +: 4];
      tclk_q <= wreg_cc_i[1:0];
    end
    else if (cyc_wrap_w)
    begin
      hi_q   <= `STC_HI_MAX;
      tclk_q <= `STC_TCLK_MAX;
    end
    else if (steptk_w && !all0_w)
    begin
      if (low0_w)
      begin
        hi_q   <= dec_w[3:0];
        tclk_q <= `STC_TCLK_MAX;
      end
      else
        tclk_q <= tclk_q - 2'h1;
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      ctl_q      <= 1'b0;
      zero_q     <= 1'b0;
      stop_q     <= 1'b0;
      cyc_zero_q <= 1'b0;
      logout_q   <= 1'b0;
      aseq_wr_q  <= 1'b0;
      aseq_val_q <= 5'h00;
    end
    else
    begin
      ctl_q      <= ctl_set_w || (ctl_q && !ord_i.initial_load && !ord_i.test_restart);
      zero_q     <= !ld_step_w && (zero_set_w || zero_q);
      stop_q     <= (zero_set_w && !zero_q) || (stop_q && !clr_stop_w && !ord_i.initial_load);
      cyc_zero_q <= cyc_all0_w;
      logout_q   <= cyc_all0_w && !cyc_zero_q && (mode_q == STC_CNTLOG);
      aseq_wr_q  <= gnt_w[`STC_CH_ADDR];
      aseq_val_q <= gnt_w[`STC_CH_ADDR] ? dec_w : aseq_val_q;
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      seq_q      <= 3'h0;
      seq_pend_q <= 1'b0;
      enter_q    <= 1'b0;
      step_q     <= 7'h00;
    end
    else
    begin
      if (ord_i.cs_test_start)
        seq_q <= `STC_SEQ_START;
      else if (gnt_w[`STC_CH_SEQ])
        seq_q <= dec_w[2:0];
      seq_pend_q <= !ord_i.cs_test_start && req_w[`STC_CH_SEQ] && !gnt_w[`STC_CH_SEQ];
      enter_q    <= ord_i.cs_test_start || gnt_w[`STC_CH_SEQ];
      step_q     <= step_w;
    end
  end

  assign rdata_o        = rdata_q;
  assign retry_o        = retry_q_o;
  assign abandon_o      = abandon_q;
  assign addr_seq_wr_o  = aseq_wr_q;
  assign addr_seq_val_o = aseq_val_q;
  assign step_o         = step_q;
  assign cyc_zero_o     = cyc_zero_q;
  assign logout_o       = logout_q;
  assign clk_stop_o     = stop_q;

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);

  sequence s_err_taken;
    err_ok_w ##1 retry_pend_q;
  endsequence

  a_retry_load_max: assert property (ld_retry_w |=> retry_q == 5'h1F)
    else $error("retry counter not loaded with 31");
  a_retry_dec_one: assert property (s_err_taken ##0 (!ld_retry_w && gnt_w[`STC_CH_RETRY])
                                    |=> retry_q == $past(retry_q) - 5'h01)
    else $error("retry counter did not drop by one");
  a_retry_abandon: assert property (err_end_w |=> abandon_o && retry_q == 5'h00)
    else $error("abandon not raised at zero");
  a_step_blocked: assert property (!run_w && !ld_step_w && !cyc_wrap_w |=> $stable(hi_q) && $stable(tclk_q))
    else $error("step counter moved while blocked");
  a_tclk_reload: assert property (steptk_w && low0_w && !hi0_w && !ld_step_w |=> tclk_q == 2'h3)
    else $error("test-clock pair not reloaded with 3");
  a_zero_latch: assert property (zero_q && !ld_step_w |=> zero_q && $stable(hi_q))
    else $error("zero latch did not hold");
  a_seq_start: assert property (ord_i.cs_test_start |=> seq_q == 3'h7 ##1 step_o == 7'h00)
    else $error("sequencer not started at 7");
  a_grant_single: assert property ($onehot0(gnt_w) && (|req_w == |gnt_w))
    else $error("decrementer grant not single");
  a_cyc_reload: assert property (cyc_wrap_w && !ld_step_w |=> hi_q == 4'hF && tclk_q == 2'h3 && addr_seq_wr_o)
    else $error("cycle counter reload failed");
  a_stop_set: assert property (zero_set_w && !zero_q |=> clk_stop_o)
    else $error("clock stop trigger not set");
endmodule : stc_counters

// ==== src/stc_map.svh ====
// Offsets, field positions, reset values and fixed counts of the scan test counters.
`ifndef STC_MAP_SVH
`define STC_MAP_SVH
`define STC_ADDR_W        2
`define STC_REG_CTRL      2'h0
`define STC_REG_STAT      2'h1
`define STC_REG_CNT       2'h2
`define STC_CTRL_MODE_LSB 0
`define STC_CTRL_ACMP_BIT 2
`define STC_CTRL_CLR_BIT  3
`define STC_CTRL_RST      3'h0
`define STC_RETRY_MAX     5'h1F
`define STC_TCLK_MAX      2'h3
`define STC_HI_MAX        4'hF
`define STC_SEQ_START     3'h7
`define STC_CC_HI_LSB     2
`define STC_CH_STEP       0
`define STC_CH_ADDR       1
`define STC_CH_SEQ        2
`define STC_CH_RETRY      3
`define STC_CH_N          4
`endif

// ==== src/stc_pkg.sv ====
// Types shared by the scan test counter modules.
package stc_pkg;
  typedef enum logic [1:0] {
    STC_LOGIC,
    STC_CSTEST,
    STC_PULSE,
    STC_CNTLOG
  } stc_mode_t;

  typedef struct packed {
    logic load_retry_order;
    logic decrement_retry_order;
    logic set_counter_control_order;
    logic load_control_word_order;
    logic cs_test_start;
    logic initial_load;
    logic test_restart;
  } stc_orders_t;

  typedef struct packed {
    logic gap_trigger;
    logic repeat_latch;
    logic pass_trigger;
    logic fail_trigger;
    logic unconditional_test_bit;
    logic result_zero;
    logic input_error;
    logic scan_store_request_trigger;
    logic addr_match;
  } stc_cond_t;
endpackage : stc_pkg

// ==== src/stc_scan_decr.sv ====
// Shared scan decrementer with a one-grant-per-cycle priority arbiter.
`include "stc_map.svh"
module stc_scan_decr (
  input  wire logic [`STC_CH_N-1:0]      req_i,
  input  wire logic [`STC_CH_N-1:0][4:0] val_i,
  output logic      [`STC_CH_N-1:0]      gnt_o,
  output logic      [4:0]                res_o
);
  function automatic logic [`STC_CH_N-1:0] pick(input logic [`STC_CH_N-1:0] r);
    logic [`STC_CH_N-1:0] g;
    g = '0;
    for (int i = `STC_CH_N - 1; i >= 0; i--)
    begin
      if (r[i])
      begin
        g = '0;
        g[i] = 1'b1;
      end
    end
    return g;
  endfunction : pick

  wire logic [4:0] sel_w;

  assign gnt_o = pick(req_i);
  assign sel_w = gnt_o[0] ? val_i[0] : gnt_o[1] ? val_i[1] : gnt_o[2] ? val_i[2] : val_i[3];
  assign res_o = sel_w - 5'h01;
endmodule : stc_scan_decr

// ==== src/stc_step_decoder.sv ====
// Decodes test-step sequencer values 0-6 into one of seven step signals; value 7 raises none.
module stc_step_decoder (
  input  wire logic [2:0] seq_i,
  output logic      [6:0] step_o
);
  wire logic [7:0] hot_w;

  assign hot_w  = 8'h01 << seq_i;
  assign step_o = hot_w[6:0];
endmodule : stc_step_decoder

// ==== tb/stc_seq_model.sv ====
// Address sequencer model that sits beside the counters and takes their write-back.
module stc_seq_model #(
  parameter logic [4:0] INIT = 5'h02
) (
  input  wire logic       clk_sys_i,
  input  wire logic       rst_i,
  input  wire logic       wr_i,
  input  wire logic [4:0] val_i,
  output logic      [4:0] addr_seq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      addr_seq_o <= INIT;
    else if (wr_i)
      addr_seq_o <= val_i;
  end
endmodule : stc_seq_model

// ==== tb/stc_counters_tb.sv ====
// Self-checking testbench of the scan test counters.
module stc_counters_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import stc_pkg::*;
  localparam logic [6:0] O_LDR = 7'h40;
  localparam logic [6:0] O_DEC = 7'h20;
  localparam logic [6:0] O_CTL = 7'h10;
  localparam logic [6:0] O_LCW = 7'h08;
  localparam logic [6:0] O_CST = 7'h04;
  localparam logic [6:0] O_IPL = 7'h02;
  logic        clk_sys_i = 1'b0;
  logic        rst_i = 1'b1;
  stc_orders_t ord_i = '0;
  stc_cond_t   cond_i = '0;
  logic        scan_tick_i = 1'b0;
  logic [5:0]  wreg_cc_i = 6'h00;
  logic [4:0]  addr_seq;
  logic [1:0]  addr_i = 2'h0;
  logic [31:0] wdata_i = 32'h0;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic [31:0] rdata_o;
  logic        retry_o, abandon_o, addr_seq_wr_o, cyc_zero_o, logout_o, clk_stop_o;
  logic [4:0]  addr_seq_val_o;
  logic [6:0]  step_o;
  logic [31:0] d;
  int          num_errors = 0;
  int          n_checks = 0;
  logic        saw_logout = 1'b0;
  always #50 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i)
    if (logout_o)
      saw_logout <= 1'b1;
  stc_counters dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ord_i(ord_i), .cond_i(cond_i),
    .scan_tick_i(scan_tick_i), .wreg_cc_i(wreg_cc_i), .addr_seq_i(addr_seq), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .retry_o(retry_o),
    .abandon_o(abandon_o), .addr_seq_wr_o(addr_seq_wr_o), .addr_seq_val_o(addr_seq_val_o),
    .step_o(step_o), .cyc_zero_o(cyc_zero_o), .logout_o(logout_o), .clk_stop_o(clk_stop_o));
  stc_seq_model far (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .wr_i(addr_seq_wr_o),
    .val_i(addr_seq_val_o), .addr_seq_o(addr_seq));
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp, input string msg);
    n_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("Error at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask : chk32
  task automatic chk1(input logic got, input logic exp, input string msg);
    chk32({31'h0, got}, {31'h0, exp}, msg);
  endtask : chk1
  task automatic wr_reg(input logic [1:0] a, input logic [31:0] v);
    @(posedge clk_sys_i);
    wr_i    <= 1'b1;
    addr_i  <= a;
    wdata_i <= v;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [1:0] a, output logic [31:0] v);
    @(posedge clk_sys_i);
    rd_i   <= 1'b1;
    addr_i <= a;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    #1 v = rdata_o;
  endtask : rd_reg
  task automatic pulse(input logic [6:0] o);
    @(posedge clk_sys_i);
    ord_i <= stc_orders_t'(o);
    @(posedge clk_sys_i);
    ord_i <= '0;
    #1;
  endtask : pulse
  task automatic tick();
    @(posedge clk_sys_i);
    scan_tick_i <= 1'b1;
    @(posedge clk_sys_i);
    scan_tick_i <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    #1;
  endtask : tick
  task automatic t_reset_map();
    rd_reg(2'h2, d);
    chk32(d, 32'h1F, "cnt after reset");
    rd_reg(2'h1, d);
    chk32(d, 32'h0, "status after reset");
    wr_reg(2'h3, 32'hFFFF_FFFF);
    rd_reg(2'h3, d);
    chk32(d, 32'h0, "unmapped read");
    $display("test reset_map done");
  endtask : t_reset_map
  task automatic t_retry_abandon();
    for (int i = 0; i < 31; i++)
    begin
      pulse(O_DEC);
      chk1(retry_o, 1'b1, "retry pulse");
      repeat (3) @(posedge clk_sys_i);
    end
    rd_reg(2'h2, d);
    chk32({27'h0, d[4:0]}, 32'h0, "retry at zero");
    pulse(O_DEC);
    chk1(abandon_o, 1'b1, "abandon on 32nd error");
    repeat (3) @(posedge clk_sys_i);
    pulse(O_LDR);
    rd_reg(2'h2, d);
    chk32({27'h0, d[4:0]}, 32'h0, "load without gap");
    cond_i.gap_trigger <= 1'b1;
    pulse(O_LDR);
    cond_i.gap_trigger <= 1'b0;
    rd_reg(2'h2, d);
    chk32({27'h0, d[4:0]}, 32'h1F, "load with gap");
    $display("test retry_abandon done");
  endtask : t_retry_abandon
  task automatic t_step_count();
    wreg_cc_i <= 6'h06;
    pulse(O_LCW);
    rd_reg(2'h2, d);
    chk32({26'h0, d[10:5]}, 32'h06, "control word load");
    pulse(O_CTL);
    repeat (3) tick();
    rd_reg(2'h2, d);
    chk32({26'h0, d[10:5]}, 32'h03, "pair reload and high step");
    repeat (3) tick();
    chk1(clk_stop_o, 1'b1, "clock stop at zero");
    rd_reg(2'h1, d);
    chk32(d, 32'h1C, "status latches at zero");
    tick();
    rd_reg(2'h2, d);
    chk32({26'h0, d[10:5]}, 32'h0, "no count past zero");
    pulse(O_IPL);
    @(posedge clk_sys_i);
    #1 chk1(clk_stop_o, 1'b0, "initial load clears stop");
    rd_reg(2'h2, d);
    chk32({27'h0, d[4:0]}, 32'h1F, "initial load sets retry");
    $display("test step_count done");
  endtask : t_step_count
  task automatic t_sequencer();
    wreg_cc_i <= 6'h03;
    pulse(O_LCW);
    wr_reg(2'h0, 32'h1);
    pulse(O_CST);
    rd_reg(2'h2, d);
    chk32({29'h0, d[13:11]}, 32'h7, "sequencer start");
    chk32({25'h0, step_o}, 32'h0, "no step at 7");
    tick();
    chk32({25'h0, step_o}, 32'h40, "step six");
    @(posedge clk_sys_i);
    cond_i.input_error <= 1'b1;
    @(posedge clk_sys_i);
    cond_i.input_error <= 1'b0;
    #1 chk1(retry_o, 1'b1, "error retry in cs mode");
    repeat (3) @(posedge clk_sys_i);
    rd_reg(2'h2, d);
    chk32({27'h0, d[4:0]}, 32'h1E, "retry after cs error");
    tick();
    chk32({25'h0, step_o}, 32'h20, "step five");
    $display("test sequencer done");
  endtask : t_sequencer
  task automatic t_cycle_count();
    wr_reg(2'h0, 32'h0);
    wreg_cc_i <= 6'h01;
    pulse(O_LCW);
    pulse(O_CTL);
    wr_reg(2'h0, 32'h3);
    tick();
    tick();
    chk32({27'h0, addr_seq}, 32'h1, "address sequencer step");
    rd_reg(2'h2, d);
    chk32({26'h0, d[10:5]}, 32'h3F, "cycle counter reload");
    repeat (127) tick();
    chk1(cyc_zero_o, 1'b1, "cycle counter zero");
    chk1(clk_stop_o, 1'b1, "clock stop on cycle zero");
    chk1(saw_logout, 1'b1, "logout started");
    $display("test cycle_count done");
  endtask : t_cycle_count
  task automatic conclude();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : conclude
  initial
  begin
    #2000000;
    num_errors++;
    conclude();
  end
  initial
  begin
    repeat (2) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    t_reset_map();
    t_retry_abandon();
    t_step_count();
    t_sequencer();
    t_cycle_count();
    conclude();
  end
endmodule : stc_counters_tb
